// file: hdl/ims_output_regs.sv
// module: sensor output register bank behind an APB slave
//
// Operation
// R1 - accel X,Y,Z words at 0x19 to 0x1E
// R2 - low byte lower address, high byte next
// R3 - rate X,Y,Z words at 0x1F to 0x24
// R4 - field X,Y,Z words at 0x25 to 0x2A
// R5 - quaternion W,X,Y,Z words at 0x2D to 0x34
// R6 - velocity X,Y,Z words at 0x35 to 0x3A
// R7 - output rate code 111 loads low-latency rate
// R8 - self-test results load velocity registers
// R9 - temperature byte at 0x3B
// R10 - bit 7 flags field bias update
// R11 - bit 6 flags rate bias update
// R12 - bits 5..3 flag rate Z,Y,X clipping
// R13 - bits 2..0 flag accel Z,Y,X clipping
// R14 - new-sample flags set, cleared by read
// R15 - both bytes of a word update together
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module ims_output_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sample inputs
  input wire ims_pkg::ims_vec3_type accel_i,
  input wire ims_pkg::ims_vec3_type rate_i,
  input wire ims_pkg::ims_vec3_type field_i,
  input wire ims_pkg::ims_quat_type quat_i,
  input wire ims_pkg::ims_integ_type integ_i,
  input wire ims_pkg::ims_vec3_type vel_i,
  input wire ims_pkg::ims_vec3_type ll_rate_i,
  input wire ims_pkg::ims_vec3_type self_test_i,
  input wire ims_pkg::ims_temp_type temp_i,
  // configuration seen by the sensor side
  output logic [2:0] rate_output_rate_field_o
);
  import ims_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [15:0] word_r [IMS_NWORDS];
  logic [15:0] src_word [IMS_NWORDS];
  logic src_load [IMS_NWORDS];
  logic [7:0] temp_r;
  ims_integ_type status_r;
  logic [2:0] odr_r;
  logic [IMS_NFLAGS-1:0] flags_r;
  logic [IMS_NFLAGS-1:0] flags_nxt;
  logic [IMS_NFLAGS-1:0] clr_r;
  logic [IMS_NFLAGS-1:0] flag_set;
  logic [31:0] rd_data_r;
  logic err_r;
  ims_vec3_type vel_src;

  // ****************************************
  // apb decode
  // ****************************************
  logic setup;
  logic access;
  logic [7:0] idx;
  logic aligned;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [7:0] off;
  logic [3:0] wsel;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign idx = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'h0) & (paddr_i[11:10] == 2'h0);

  // ****************************************
  // velocity source select
  // ****************************************
  // self test has priority: its results must not be overwritten mid-test
  always_comb begin
    vel_src = vel_i;
    if (self_test_i.valid) begin
      vel_src = self_test_i; // R8
    end else if (odr_r == IMS_ODR_LOW_LATENCY) begin
      vel_src = ll_rate_i; // R7
    end
  end

  // ****************************************
  // word load sources
  // ****************************************
  always_comb begin
    for (int k = 0; k < IMS_NWORDS; k++) begin
      src_word[k] = IMS_WORD_RST;
      src_load[k] = 1'b0;
    end
    for (int k = 0; k < 3; k++) begin
      src_word[IMS_W_ACCEL+k] = accel_i[16*k +: 16]; // R1
      src_load[IMS_W_ACCEL+k] = accel_i.valid;
      src_word[IMS_W_RATE+k] = rate_i[16*k +: 16]; // R3
      src_load[IMS_W_RATE+k] = rate_i.valid;
      src_word[IMS_W_FIELD+k] = field_i[16*k +: 16]; // R4
      src_load[IMS_W_FIELD+k] = field_i.valid;
      src_word[IMS_W_VEL+k] = vel_src[16*k +: 16]; // R6
      src_load[IMS_W_VEL+k] = vel_src.valid;
    end
    for (int k = 0; k < 4; k++) begin
      src_word[IMS_W_QUAT+k] = quat_i[16*k +: 16]; // R5
      src_load[IMS_W_QUAT+k] = quat_i.valid;
    end
  end

  // whole 16-bit words load at once, so both halves share one sample
  for (genvar g = 0; g < IMS_NWORDS; g++) begin : g_word
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        word_r[g] <= IMS_WORD_RST;
      end else if (src_load[g]) begin
        word_r[g] <= src_word[g]; // R15
      end
    end
  end

  // ****************************************
  // temperature and integrator status
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_r <= IMS_BYTE_RST;
    end else if (temp_i.valid) begin
      temp_r <= temp_i.value; // R9
    end
  end

  // status describes the output period of the quaternion just loaded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= IMS_BYTE_RST;
    end else if (quat_i.valid) begin
      status_r <= integ_i; // R10 R11 R12 R13
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odr_r <= IMS_ODR_RST;
    end else if (access & pwrite_i & aligned & (idx == IMS_IDX_CONFIG) & pstrb_i[0]) begin
      odr_r <= pwdata_i[2:0];
    end
  end

  assign rate_output_rate_field_o = odr_r;

  // ****************************************
  // new-sample flags
  // ****************************************
  assign flag_set = {quat_i.valid, field_i.valid, rate_i.valid, accel_i.valid};

  // only flags seen by the read are cleared; a new sample wins over the clear
  always_comb begin
    flags_nxt = flags_r;
    if (access) begin
      flags_nxt = flags_r & ~clr_r;
    end
    flags_nxt = flags_nxt | flag_set; // R14
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_val = IMS_DATA_ZERO;
    rd_hit = 1'b0;
    off = IMS_BYTE_RST;
    wsel = 4'h0;
    if (aligned) begin
      if ((idx >= IMS_IDX_ACCEL_X_LOW) && (idx <= IMS_IDX_FIELD_Z_HIGH)) begin
        off = idx - IMS_IDX_ACCEL_X_LOW;
        wsel = off[4:1];
        rd_hit = 1'b1;
      end else if ((idx >= IMS_IDX_QUAT_INC_W_LOW) && (idx <= IMS_IDX_VEL_INC_Z_HIGH)) begin
        off = idx - IMS_IDX_QUAT_INC_W_LOW;
        wsel = 4'(IMS_W_QUAT) + off[4:1];
        rd_hit = 1'b1;
      end
      if (rd_hit) begin
        // even offset is the low byte
        rd_val[7:0] = off[0] ? word_r[wsel][15:8] : word_r[wsel][7:0]; // R2
      end
      unique case (idx)
        IMS_IDX_TEMPERATURE_OUT: begin
          rd_val[7:0] = temp_r;
          rd_hit = 1'b1;
        end
        IMS_IDX_INTEGRATOR_STATUS_ONE: begin
          rd_val[7:0] = status_r;
          rd_hit = 1'b1;
        end
        IMS_IDX_CONFIG: begin
          rd_val[2:0] = odr_r;
          rd_hit = 1'b1;
        end
        IMS_IDX_NEW_FLAGS: begin
          rd_val[IMS_NFLAGS-1:0] = flags_r;
          rd_hit = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // apb response
  // ****************************************
  // read data captured in setup so it is a flop output in the access phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= IMS_DATA_ZERO;
      err_r <= 1'b0;
      clr_r <= '0;
    end else if (setup) begin
      rd_data_r <= pwrite_i ? IMS_DATA_ZERO : rd_val;
      err_r <= ~rd_hit;
      clr_r <= (~pwrite_i & aligned & (idx == IMS_IDX_NEW_FLAGS)) ?
               rd_val[IMS_NFLAGS-1:0] : '0;
    end
  end

  assign prdata_o = rd_data_r;
  assign pready_o = 1'b1;
  assign pslverr_o = access & err_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_setup;
  assign rd_setup = setup & ~pwrite_i & aligned;

  AST_ACCEL_X_LOW: assert property ( // R1
    rd_setup & (idx == IMS_IDX_ACCEL_X_LOW) |=> prdata_o[7:0] == $past(word_r[0][7:0]))
    else $error("accel x low byte misread");

  AST_ACCEL_X_HIGH: assert property ( // R2
    rd_setup & (idx == IMS_IDX_ACCEL_X_HIGH) |=> prdata_o == {24'h0, $past(word_r[0][15:8])})
    else $error("accel x high byte misread");

  AST_RATE_Z_HIGH: assert property ( // R3
    rd_setup & (idx == IMS_IDX_RATE_Z_HIGH) |=> prdata_o[7:0] == $past(word_r[5][15:8]))
    else $error("rate z high byte misread");

  AST_FIELD_Y_LOW: assert property ( // R4
    rd_setup & (idx == IMS_IDX_FIELD_Y_LOW) |=> prdata_o[7:0] == $past(word_r[7][7:0]))
    else $error("field y low byte misread");

  AST_QUAT_W_LOW: assert property ( // R5
    rd_setup & (idx == IMS_IDX_QUAT_INC_W_LOW) |=> prdata_o[7:0] == $past(word_r[IMS_W_QUAT][7:0]))
    else $error("quaternion w low byte misread");

  AST_VEL_Z_HIGH: assert property ( // R6
    rd_setup & (idx == IMS_IDX_VEL_INC_Z_HIGH) |=> prdata_o[7:0] == $past(word_r[15][15:8]))
    else $error("velocity z high byte misread");

  AST_LOW_LATENCY: assert property ( // R7
    (odr_r == IMS_ODR_LOW_LATENCY) & ll_rate_i.valid & ~self_test_i.valid
      |=> word_r[IMS_W_VEL] == $past(ll_rate_i.x))
    else $error("low-latency rate not loaded");

  AST_SELF_TEST: assert property ( // R8
    self_test_i.valid |=> word_r[IMS_W_VEL+2] == $past(self_test_i.z))
    else $error("self-test result not loaded");

  AST_TEMP: assert property ( // R9
    rd_setup & (idx == IMS_IDX_TEMPERATURE_OUT) |=> prdata_o == {24'h0, $past(temp_r)})
    else $error("temperature misread");

  AST_FIELD_BIAS: assert property ( // R10
    quat_i.valid |=> status_r[7] == $past(integ_i.field_bias_updated))
    else $error("field bias ack wrong");

  AST_RATE_BIAS: assert property ( // R11
    quat_i.valid |=> status_r[6] == $past(integ_i.rate_bias_updated))
    else $error("rate bias ack wrong");

  AST_RATE_CLIP: assert property ( // R12
    quat_i.valid |=> status_r[5:3] ==
      $past({integ_i.rate_z_clipped, integ_i.rate_y_clipped, integ_i.rate_x_clipped}))
    else $error("rate clip bits wrong");

  AST_ACCEL_CLIP: assert property ( // R13
    quat_i.valid |=> status_r[2:0] ==
      $past({integ_i.accel_z_clipped, integ_i.accel_y_clipped, integ_i.accel_x_clipped}))
    else $error("accel clip bits wrong");

  AST_FLAG_SET_WINS: assert property ( // R14
    accel_i.valid |=> flags_r[IMS_FLG_ACCEL])
    else $error("new-sample flag lost");

  AST_FLAG_CLEAR: assert property ( // R14
    access & clr_r[IMS_FLG_RATE] & ~rate_i.valid |=> ~flags_r[IMS_FLG_RATE])
    else $error("rate flag not cleared by read");

  AST_WORD_WHOLE: assert property ( // R15
    rate_i.valid |=> word_r[IMS_W_RATE+1] == $past(rate_i.y))
    else $error("rate word torn");

  AST_UNMAPPED: assert property (
    setup & ~pwrite_i & aligned & (idx == 8'h2B) |=> pslverr_o & (prdata_o == 32'h0))
    else $error("unmapped read not refused");

  AST_ACCEL_Z_LOAD: assert property ( // R1
    accel_i.valid |=> word_r[IMS_W_ACCEL+2] == $past(accel_i.z))
    else $error("accel z word not loaded");

  AST_RATE_X_LOW: assert property ( // R3
    rd_setup & (idx == IMS_IDX_RATE_X_LOW) |=> prdata_o[7:0] == $past(word_r[IMS_W_RATE][7:0]))
    else $error("rate x low byte misread");

  AST_FIELD_LOAD: assert property ( // R4
    field_i.valid |=> word_r[IMS_W_FIELD] == $past(field_i.x))
    else $error("field x word not loaded");

  AST_QUAT_LOAD: assert property ( // R5
    quat_i.valid |=> word_r[IMS_W_QUAT] == $past(quat_i.w))
    else $error("quaternion w word not loaded");

  AST_VEL_LOAD: assert property ( // R6
    vel_i.valid & ~self_test_i.valid & (odr_r != IMS_ODR_LOW_LATENCY)
      |=> word_r[IMS_W_VEL+1] == $past(vel_i.y))
    else $error("velocity y word not loaded");

  AST_VEL_HOLD: assert property ( // R6
    ~vel_i.valid & ~ll_rate_i.valid & ~self_test_i.valid |=> $stable(word_r[IMS_W_VEL]))
    else $error("velocity word changed without a sample");

  AST_CONFIG_WRITE: assert property ( // R7
    access & pwrite_i & aligned & (idx == IMS_IDX_CONFIG) & pstrb_i[0]
      |=> rate_output_rate_field_o == $past(pwdata_i[2:0]))
    else $error("output rate field write lost");

  AST_TEMP_LOAD: assert property ( // R9
    temp_i.valid |=> temp_r == $past(temp_i.value))
    else $error("temperature not loaded");

  AST_STATUS_HOLD: assert property ( // R10
    ~quat_i.valid |=> $stable(status_r))
    else $error("integrator status changed between periods");

  AST_FLAG_QUAT: assert property ( // R14
    quat_i.valid |=> flags_r[IMS_FLG_QUAT])
    else $error("quaternion new-sample flag lost");

  AST_WORD_HOLD: assert property ( // R15
    ~accel_i.valid |=> $stable(word_r[IMS_W_ACCEL+1]))
    else $error("accel word changed without a sample");

endmodule

// file: hdl/ims_pkg.sv
// package: register map, constants and carrier types of the sensor output bank
package ims_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IMS_IDX_ACCEL_X_LOW = 8'h19;
  localparam logic [7:0] IMS_IDX_ACCEL_X_HIGH = 8'h1A;
  localparam logic [7:0] IMS_IDX_ACCEL_Z_HIGH = 8'h1E;
  localparam logic [7:0] IMS_IDX_RATE_X_LOW = 8'h1F;
  localparam logic [7:0] IMS_IDX_RATE_Z_HIGH = 8'h24;
  localparam logic [7:0] IMS_IDX_FIELD_X_LOW = 8'h25;
  localparam logic [7:0] IMS_IDX_FIELD_Y_LOW = 8'h27;
  localparam logic [7:0] IMS_IDX_FIELD_Z_HIGH = 8'h2A;
  localparam logic [7:0] IMS_IDX_QUAT_INC_W_LOW = 8'h2D;
  localparam logic [7:0] IMS_IDX_QUAT_INC_Z_HIGH = 8'h34;
  localparam logic [7:0] IMS_IDX_VEL_INC_X_LOW = 8'h35;
  localparam logic [7:0] IMS_IDX_VEL_INC_Z_HIGH = 8'h3A;
  localparam logic [7:0] IMS_IDX_TEMPERATURE_OUT = 8'h3B;
  localparam logic [7:0] IMS_IDX_INTEGRATOR_STATUS_ONE = 8'h3C;
  localparam logic [7:0] IMS_IDX_CONFIG = 8'h40;
  localparam logic [7:0] IMS_IDX_NEW_FLAGS = 8'h41;

  // ****************************************
  // word store layout
  // ****************************************
  localparam int IMS_NWORDS = 16;
  localparam int IMS_W_ACCEL = 0;
  localparam int IMS_W_RATE = 3;
  localparam int IMS_W_FIELD = 6;
  localparam int IMS_W_QUAT = 9;
  localparam int IMS_W_VEL = 13;
  localparam int IMS_NFLAGS = 4;
  localparam int IMS_FLG_ACCEL = 0;
  localparam int IMS_FLG_RATE = 1;
  localparam int IMS_FLG_FIELD = 2;
  localparam int IMS_FLG_QUAT = 3;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [15:0] IMS_WORD_RST = 16'h0000;
  localparam logic [7:0] IMS_BYTE_RST = 8'h00;
  localparam logic [31:0] IMS_DATA_ZERO = 32'h0000_0000;
  localparam logic [2:0] IMS_ODR_RST = 3'h0;
  localparam logic [2:0] IMS_ODR_LOW_LATENCY = 3'h7;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } ims_vec3_type;

  typedef struct packed {
    logic valid;
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
    logic [15:0] w;
  } ims_quat_type;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } ims_temp_type;

  typedef struct packed {
    logic field_bias_updated;
    logic rate_bias_updated;
    logic rate_z_clipped;
    logic rate_y_clipped;
    logic rate_x_clipped;
    logic accel_z_clipped;
    logic accel_y_clipped;
    logic accel_x_clipped;
  } ims_integ_type;

endpackage

// file: verification/ims_host.sv
// host model: APB master that reads and writes the output register bank
`timescale 1ns/10ps
module ims_host (
  // clock
  input wire logic clk_i,
  // apb master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // request held until pready is seen high at an access edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= {2'b00, idx, 2'b00};
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// file: verification/ims_output_regs_test.sv
// testbench: output register bank driven by the host model
`timescale 1ns/10ps
module ims_output_regs_test;
  import ims_pkg::*;
  logic clk_i;
  logic rst_i;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] odr;
  ims_vec3_type accel, rate, field, vel, ll_rate, self_test;
  ims_quat_type quat;
  ims_integ_type integ;
  ims_temp_type temp;
  int fails;
  int check_count;

  ims_host host_u (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  ims_output_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .accel_i(accel),
    .rate_i(rate), .field_i(field), .quat_i(quat), .integ_i(integ), .vel_i(vel),
    .ll_rate_i(ll_rate), .self_test_i(self_test), .temp_i(temp),
    .rate_output_rate_field_o(odr));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    host_u.xfer(wr, idx, wd, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, experr});
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, IMS_DATA_ZERO, {24'h000000, exp}, 1'b0);
  endtask

  task automatic vchk(input logic [7:0] idx, input logic [63:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      rdchk(idx + 8'(k), v[8*k +: 8]);
    end
  endtask

  // valids are one-cycle pulses
  task automatic drop;
    @(posedge clk_i);
    {accel.valid, rate.valid, field.valid, vel.valid} <= 4'h0;
    {ll_rate.valid, self_test.valid, quat.valid, temp.valid} <= 4'h0;
  endtask

  task automatic qstat(input logic [7:0] s);
    @(posedge clk_i);
    quat <= ims_quat_type'{1'b1, 16'h0404, 16'h0303, 16'h0202, 16'h0101};
    integ <= ims_integ_type'(s);
    drop();
    rdchk(IMS_IDX_INTEGRATOR_STATUS_ONE, s);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 8'h19; i <= 8'h3C; i++) begin
      if (i != 8'h2B && i != 8'h2C) rdchk(8'(i), IMS_BYTE_RST);
    end
    chk({29'h0, odr}, 32'h0);
  endtask

  task automatic t_vectors;
    @(posedge clk_i);
    accel <= ims_vec3_type'{1'b1, 16'h8001, 16'h7FFE, 16'h1234};
    rate <= ims_vec3_type'{1'b1, 16'hC00C, 16'hB00B, 16'hA00A};
    field <= ims_vec3_type'{1'b1, 16'hF11F, 16'hE11E, 16'hD11D};
    drop();
    vchk(IMS_IDX_ACCEL_X_LOW, {16'h0, 48'h8001_7FFE_1234}, 6);
    vchk(IMS_IDX_RATE_X_LOW, {16'h0, 48'hC00C_B00B_A00A}, 6);
    vchk(IMS_IDX_FIELD_X_LOW, {16'h0, 48'hF11F_E11E_D11D}, 6);
    rdchk(IMS_IDX_NEW_FLAGS, 8'h07);
    rdchk(IMS_IDX_NEW_FLAGS, 8'h00);
    @(posedge clk_i);
    accel <= ims_vec3_type'{1'b1, 16'h8001, 16'h7FFE, 16'hFF00};
    drop();
    vchk(IMS_IDX_ACCEL_X_LOW, {48'h0, 16'hFF00}, 2);
    acc(1'b1, IMS_IDX_ACCEL_X_LOW, 32'h0000_00FF, IMS_DATA_ZERO, 1'b0);
    rdchk(IMS_IDX_ACCEL_X_LOW, 8'h00);
    acc(1'b0, 8'h2B, IMS_DATA_ZERO, IMS_DATA_ZERO, 1'b1);
  endtask

  task automatic t_quat;
    qstat(8'h80);
    qstat(8'h40);
    qstat(8'h38);
    qstat(8'h07);
    vchk(IMS_IDX_QUAT_INC_W_LOW, 64'h0404_0303_0202_0101, 8);
    rdchk(IMS_IDX_NEW_FLAGS, 8'h09);
  endtask

  task automatic t_vel;
    @(posedge clk_i);
    vel <= ims_vec3_type'{1'b1, 16'h3003, 16'h2002, 16'h1001};
    temp <= ims_temp_type'{1'b1, 8'hE7};
    drop();
    vchk(IMS_IDX_VEL_INC_X_LOW, {16'h0, 48'h3003_2002_1001}, 6);
    rdchk(IMS_IDX_TEMPERATURE_OUT, 8'hE7);
    acc(1'b1, IMS_IDX_CONFIG, 32'h7, IMS_DATA_ZERO, 1'b0);
    // config lands at the access edge; look once it has settled
    @(posedge clk_i);
    chk({29'h0, odr}, {29'h0, IMS_ODR_LOW_LATENCY});
    @(posedge clk_i);
    vel <= ims_vec3_type'{1'b1, 16'h3003, 16'h2002, 16'h1001};
    ll_rate <= ims_vec3_type'{1'b1, 16'h6006, 16'h5005, 16'h4004};
    drop();
    vchk(IMS_IDX_VEL_INC_X_LOW, {16'h0, 48'h6006_5005_4004}, 6);
    @(posedge clk_i);
    ll_rate <= ims_vec3_type'{1'b1, 16'h6006, 16'h5005, 16'h4004};
    self_test <= ims_vec3_type'{1'b1, 16'h9009, 16'h8008, 16'h7007};
    drop();
    vchk(IMS_IDX_VEL_INC_X_LOW, {16'h0, 48'h9009_8008_7007}, 6);
    acc(1'b1, IMS_IDX_CONFIG, 32'h0, IMS_DATA_ZERO, 1'b0);
    @(posedge clk_i);
    vel <= ims_vec3_type'{1'b1, 16'h0C0C, 16'h0B0B, 16'h0A0A};
    ll_rate <= ims_vec3_type'{1'b1, 16'h6006, 16'h5005, 16'h4004};
    drop();
    vchk(IMS_IDX_VEL_INC_X_LOW, {16'h0, 48'h0C0C_0B0B_0A0A}, 6);
  endtask

  task automatic summarize;
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    {accel, rate, field, vel, ll_rate, self_test} = '0;
    quat = '0;
    integ = '0;
    temp = '0;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_vectors();
    t_quat();
    t_vel();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule
